/* design/pattern_source_regs.svh */
// register map, field positions, reset values and sizes of the pattern source
// assumes byte addresses on an 11-bit register port, 32-bit data
`ifndef PATTERN_SOURCE_REGS_SVH
`define PATTERN_SOURCE_REGS_SVH

`define DATA_W          32
`define ADDR_W          11
`define PAT_DEPTH       256
`define PAT_IDX_W       8
`define PAT_BASE        11'h000
`define PAT_END         11'h3FF
`define CUST_BASE       11'h400
`define CUST_END        11'h40F
`define PRBS_BASE       11'h420
`define PRBS_END        11'h43F
`define SEL_BASE        11'h440
`define SEL_END         11'h447
`define CTRL_OFS        3'h0
`define LEN_OFS         3'h1
`define STAT_OFS        3'h2
`define SEED_OFS        3'h1
`define ENABLE_BIT      0
`define INVERT_BIT      1
`define SELECT_BIT      0
`define LEN_RESET       9'h001
`define PRBS_SEED_RESET 32'h00000001
`define PRBS_POLY       32'h80200003

`endif

/* design/pattern_source_pkg.sv */
// shared types of the pattern source
// assumes the constants header is included by users for numbers
package pattern_source_pkg;
  typedef enum logic [2:0] {
    REG_NONE,
    REG_PAT,
    REG_CUST,
    REG_PRBS,
    REG_SEL
  } unit_t;
endpackage

/* design/prbs_step.sv */
`timescale 1ns/1ps
// prbs word generator: galois lfsr, one step per accepted word
// assumes seed is nonzero; a zero seed is replaced by one
`include "pattern_source_regs.svh"
module prbs_step (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               load,
  input  wire logic [`DATA_W-1:0] seed,
  input  wire logic               advance,
  output logic      [`DATA_W-1:0] word
);
  typedef struct packed {
    logic [`DATA_W-1:0] lfsr;
  } prbs_state_t;

  prbs_state_t s_q;
  prbs_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.lfsr = (seed == '0) ? `PRBS_SEED_RESET : seed;
    end else if (advance) begin
      // maximal-length taps give period 2**width - 1
      s_d.lfsr = {1'b0, s_q.lfsr[`DATA_W-1:1]}
               ^ (s_q.lfsr[0] ? `PRBS_POLY : '0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{lfsr: `PRBS_SEED_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign word = s_q.lfsr;

  property p_prbs_never_zero;
    @(posedge clk) disable iff (rst) s_q.lfsr != '0;
  endproperty
  a_prbs_never_zero: assert property (p_prbs_never_zero)
    else $error("prbs state reached zero");

  property p_prbs_hold;
    @(posedge clk) disable iff (rst) !advance && !load |=> $stable(s_q.lfsr);
  endproperty
  a_prbs_hold: assert property (p_prbs_hold)
    else $error("prbs moved without acceptance");
endmodule // prbs_step

/* design/pattern_store.sv */
`timescale 1ns/1ps
// write-only pattern memory for the custom generator
// assumes one word per aligned byte address; the only read port feeds the custom generator
`include "pattern_source_regs.svh"
module pattern_store (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 wr_en,
  input  wire logic [`PAT_IDX_W-1:0] wr_idx,
  input  wire logic [`DATA_W-1:0]   wr_data,
  input  wire logic [`PAT_IDX_W-1:0] rd_idx,
  output logic      [`DATA_W-1:0]   rd_data
);
  typedef struct packed {
    logic [`PAT_DEPTH-1:0][`DATA_W-1:0] mem;
  } store_state_t;

  store_state_t s_q;
  store_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.mem[rd_idx];

  property p_store_write;
    @(posedge clk) disable iff (rst)
      wr_en |=> s_q.mem[$past(wr_idx)] == $past(wr_data);
  endproperty
  a_store_write: assert property (p_store_write)
    else $error("pattern word not stored");
endmodule // pattern_store

/* design/pattern_source.sv */
`timescale 1ns/1ps
// data pattern source: custom repeating generator, prbs generator, selector
// assumes the register master follows one-cycle strobes, never both at once
// Contract
// - custom generator streams words continuously
// - programmed elements and length, wraps to first
// - walking patterns use data-width element count
// - frequency patterns have exactly two elements
// - synchronous prbs pattern holds 256 elements
// - pattern port is write only
// - each generator has its own control port
// - prbs period is two to width minus one
// - prbs width matches memory data width
// - prbs has control and stream ports only
// - selector forwards software-chosen input
// - first input custom, second input prbs
// - selector sustains one word per clock
// - pattern port 0x000-0x3FF, custom control 0x400
// - custom ends 0x40F, prbs 0x420-0x43F
// - selector 0x440-0x447, no overlaps
// - single shared reset for all units
// - one register port, 11-bit address
`include "pattern_source_regs.svh"
module pattern_source (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [`ADDR_W-1:0] reg_addr,
  input  wire logic [`DATA_W-1:0] reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [`DATA_W-1:0] reg_rdata,
  output logic      [`DATA_W-1:0] subsystem_stream_out_data,
  output logic                    subsystem_stream_out_valid,
  input  wire logic               subsystem_stream_out_ready
);
  function automatic pattern_source_pkg::unit_t decode(
      input logic [`ADDR_W-1:0] a);
    if (a <= `PAT_END) begin
      decode = pattern_source_pkg::REG_PAT;
    end else if (a >= `CUST_BASE && a <= `CUST_END) begin
      decode = pattern_source_pkg::REG_CUST;
    end else if (a >= `PRBS_BASE && a <= `PRBS_END) begin
      decode = pattern_source_pkg::REG_PRBS;
    end else if (a >= `SEL_BASE && a <= `SEL_END) begin
      decode = pattern_source_pkg::REG_SEL;
    end else begin
      decode = pattern_source_pkg::REG_NONE;
    end
  endfunction

  typedef struct packed {
    logic                  cust_en;
    logic                  cust_inv;
    logic [`PAT_IDX_W:0]   cust_len;
    logic [`PAT_IDX_W-1:0] cust_idx;
    logic [31:0]           cust_wraps;
    logic                  prbs_en;
    logic                  prbs_inv;
    logic [`DATA_W-1:0]    prbs_seed;
    logic [31:0]           prbs_count;
    logic                  sel_second;
    logic [`DATA_W-1:0]    rdata;
    logic [`DATA_W-1:0]    out_data;
    logic                  out_valid;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  pattern_source_pkg::unit_t unit;
  logic [2:0]                word_ofs;
  logic                      pat_wr;
  logic                      prbs_load;
  logic [`DATA_W-1:0]        cust_word;
  logic [`DATA_W-1:0]        prbs_word;
  logic [`DATA_W-1:0]        first_data;
  logic [`DATA_W-1:0]        second_data;
  logic                      first_valid;
  logic                      second_valid;
  logic                      first_ready;
  logic                      second_ready;
  logic                      out_take;
  logic                      out_room;

  assign unit      = decode(reg_addr);
  assign word_ofs  = reg_addr[4:2];
  assign pat_wr    = reg_write
                   && unit == pattern_source_pkg::REG_PAT;
  assign prbs_load = reg_write && unit == pattern_source_pkg::REG_PRBS
                   && word_ofs == `SEED_OFS;

  // walking, frequency and prbs-256 patterns are just programmed lengths
  pattern_store u_store (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (pat_wr),
    .wr_idx  (reg_addr[`PAT_IDX_W+1:2]),
    .wr_data (reg_wdata),
    .rd_idx  (s_q.cust_idx),
    .rd_data (cust_word)
  );

  // width follows the memory data width
  prbs_step u_prbs (
    .clk     (clk),
    .rst     (rst),
    .load    (prbs_load),
    .seed    (reg_wdata),
    .advance (second_valid && second_ready),
    .word    (prbs_word)
  );

  assign first_data   = s_q.cust_inv ? ~cust_word : cust_word;
  assign second_data  = s_q.prbs_inv ? ~prbs_word : prbs_word;
  assign first_valid  = s_q.cust_en;
  assign second_valid = s_q.prbs_en;

  // output register refills in the same cycle it drains: full rate
  assign out_take = s_q.out_valid && subsystem_stream_out_ready;
  assign out_room = !s_q.out_valid || subsystem_stream_out_ready;
  // unselected side stalls so no word is lost
  assign first_ready  = out_room && !s_q.sel_second;
  assign second_ready = out_room && s_q.sel_second;

  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    if (out_take) begin
      s_d.out_valid = 1'b0;
    end
    if (out_room) begin
      s_d.out_valid = s_q.sel_second ? second_valid : first_valid;
      s_d.out_data  = s_q.sel_second ? second_data : first_data;
    end
    if (first_valid && first_ready) begin
      if ({1'b0, s_q.cust_idx} + 9'h001 >= s_q.cust_len) begin
        s_d.cust_idx   = '0;
        s_d.cust_wraps = s_q.cust_wraps + 32'h00000001;
      end else begin
        s_d.cust_idx = s_q.cust_idx + 8'h01;
      end
    end
    if (second_valid && second_ready) begin
      s_d.prbs_count = s_q.prbs_count + 32'h00000001;
    end
    if (reg_write) begin
      case (unit)
        pattern_source_pkg::REG_CUST: begin
          if (word_ofs == `CTRL_OFS) begin
            s_d.cust_en  = reg_wdata[`ENABLE_BIT];
            s_d.cust_inv = reg_wdata[`INVERT_BIT];
            s_d.cust_idx = '0;
          end else if (word_ofs == `LEN_OFS) begin
            s_d.cust_len = (reg_wdata[`PAT_IDX_W:0] == '0) ? `LEN_RESET
                         : ((reg_wdata[`PAT_IDX_W:0] > 9'h100) ? 9'h100
                         : reg_wdata[`PAT_IDX_W:0]);
            s_d.cust_idx = '0;
          end
        end
        pattern_source_pkg::REG_PRBS: begin
          if (word_ofs == `CTRL_OFS) begin
            s_d.prbs_en  = reg_wdata[`ENABLE_BIT];
            s_d.prbs_inv = reg_wdata[`INVERT_BIT];
          end else if (word_ofs == `SEED_OFS) begin
            s_d.prbs_seed  = reg_wdata;
            s_d.prbs_count = '0;
          end
        end
        pattern_source_pkg::REG_SEL: begin
          if (word_ofs == `CTRL_OFS) begin
            s_d.sel_second = reg_wdata[`SELECT_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_read) begin
      case (unit)
        pattern_source_pkg::REG_CUST: begin
          case (word_ofs)
            `CTRL_OFS: s_d.rdata = {30'h0, s_q.cust_inv, s_q.cust_en};
            `LEN_OFS:  s_d.rdata = {23'h0, s_q.cust_len};
            `STAT_OFS: s_d.rdata = s_q.cust_wraps;
            3'h3:      s_d.rdata = {24'h0, s_q.cust_idx};
            default:   s_d.rdata = '0;
          endcase
        end
        pattern_source_pkg::REG_PRBS: begin
          case (word_ofs)
            `CTRL_OFS: s_d.rdata = {30'h0, s_q.prbs_inv, s_q.prbs_en};
            `SEED_OFS: s_d.rdata = s_q.prbs_seed;
            `STAT_OFS: s_d.rdata = s_q.prbs_count;
            3'h3:      s_d.rdata = prbs_word;
            default:   s_d.rdata = '0;
          endcase
        end
        pattern_source_pkg::REG_SEL: begin
          if (word_ofs == `CTRL_OFS) begin
            s_d.rdata = {31'h0, s_q.sel_second};
          end
        end
        // pattern memory is write only and reads as zero
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{cust_len: `LEN_RESET, prbs_seed: `PRBS_SEED_RESET,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata                  = s_q.rdata;
  assign subsystem_stream_out_data  = s_q.out_data;
  assign subsystem_stream_out_valid = s_q.out_valid;

  property p_wrap;
    @(posedge clk) disable iff (rst)
      first_valid && first_ready && !reg_write
      && {1'b0, s_q.cust_idx} == s_q.cust_len - 9'h001
      |=> s_q.cust_idx == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("custom index did not wrap");

  property p_idx_in_len;
    @(posedge clk) disable iff (rst) {1'b0, s_q.cust_idx} < s_q.cust_len;
  endproperty
  a_idx_in_len: assert property (p_idx_in_len)
    else $error("custom index beyond length");

  property p_unsel_stall;
    @(posedge clk) disable iff (rst)
      s_q.sel_second ? !first_ready : !second_ready;
  endproperty
  a_unsel_stall: assert property (p_unsel_stall)
    else $error("unselected input offered ready");

  property p_full_rate;
    @(posedge clk) disable iff (rst)
      s_q.out_valid && subsystem_stream_out_ready && !reg_write
      && (s_q.sel_second ? s_q.prbs_en : s_q.cust_en)
      |=> subsystem_stream_out_valid;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("selector dropped a beat");

  property p_out_hold;
    @(posedge clk) disable iff (rst)
      subsystem_stream_out_valid && !subsystem_stream_out_ready
      |=> subsystem_stream_out_valid && $stable(subsystem_stream_out_data);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("stalled output changed");

  property p_forward_second;
    @(posedge clk) disable iff (rst)
      s_q.sel_second && out_room |=> s_q.out_data == $past(second_data);
  endproperty
  a_forward_second: assert property (p_forward_second)
    else $error("second input not forwarded");

  property p_pat_reads_zero;
    @(posedge clk) disable iff (rst)
      reg_read && unit == pattern_source_pkg::REG_PAT |=> reg_rdata == '0;
  endproperty
  a_pat_reads_zero: assert property (p_pat_reads_zero)
    else $error("pattern memory read back data");

  property p_sel_read;
    @(posedge clk) disable iff (rst)
      reg_write && reg_addr == `SEL_BASE ##1 reg_read && reg_addr == `SEL_BASE
      |=> reg_rdata[0] == $past(reg_wdata[0], 2);
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("selector register mismatch");

  property p_rdata_clear;
    @(posedge clk) disable iff (rst) !reg_read |=> reg_rdata == '0;
  endproperty
  a_rdata_clear: assert property (p_rdata_clear)
    else $error("read data outlived its cycle");

  property p_cust_hold;
    @(posedge clk) disable iff (rst)
      first_valid && !first_ready && !reg_write |=> $stable(s_q.cust_idx);
  endproperty
  a_cust_hold: assert property (p_cust_hold)
    else $error("custom index moved while stalled");

  c_wrap: cover property (@(posedge clk) disable iff (rst)
    first_valid && first_ready && s_q.cust_idx != '0 ##1 s_q.cust_idx == '0);
  c_prbs_out: cover property (@(posedge clk) disable iff (rst)
    s_q.sel_second && out_take);
  c_stall: cover property (@(posedge clk) disable iff (rst)
    subsystem_stream_out_valid && !subsystem_stream_out_ready);
  c_invert: cover property (@(posedge clk) disable iff (rst)
    s_q.prbs_inv && out_take);
  c_switch: cover property (@(posedge clk) disable iff (rst)
    $changed(s_q.sel_second) && subsystem_stream_out_valid);
endmodule // pattern_source

/* test/pattern_writer_model.sv */
// stream sink standing in for the pattern writer
// assumes one clock shared with the source; ready is registered
`timescale 1ns/1ps
`include "pattern_source_regs.svh"
module pattern_writer_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [`DATA_W-1:0] data,
  input  wire logic               valid,
  input  wire logic               hold,
  input  wire logic               slow,
  output logic                    ready
);
  logic [`DATA_W-1:0] words[$];
  int                 stamps[$];
  int                 cyc;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
      cyc   <= 0;
    end else begin
      cyc <= cyc + 1;
      // random stalls expose skipped or repeated words
      ready <= !hold && (!slow || ($urandom % 3 == 0));
      if (valid && ready) begin
        words.push_back(data);
        stamps.push_back(cyc);
      end
    end
  end
endmodule // pattern_writer_model

/* test/memory_test_pattern_source_test.sv */
// self-checking bench for the pattern source
// assumes the pattern writer model as stream sink
`timescale 1ns/1ps
`include "pattern_source_regs.svh"
module memory_test_pattern_source_test;
  logic               clk;
  logic               rst;
  logic [`ADDR_W-1:0] reg_addr;
  logic [`DATA_W-1:0] reg_wdata;
  logic               reg_write;
  logic               reg_read;
  logic [`DATA_W-1:0] reg_rdata;
  logic [`DATA_W-1:0] s_data;
  logic               s_valid;
  logic               s_ready;
  logic               hold;
  logic               slow;
  logic [`DATA_W-1:0] pat [256];
  logic [`DATA_W-1:0] v;
  logic [`DATA_W-1:0] w;
  int                 num_errors;
  int                 checks;
  int                 base;
  int                 c1;
  int                 c2;

  pattern_source DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .subsystem_stream_out_data(s_data),
    .subsystem_stream_out_valid(s_valid),
    .subsystem_stream_out_ready(s_ready));
  pattern_writer_model sink (.clk(clk), .rst(rst), .data(s_data),
    .valid(s_valid), .hold(hold), .slow(slow), .ready(s_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [`DATA_W-1:0] seen,
                       input logic [`DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd_check(input logic [`ADDR_W-1:0] a,
                          input logic [`DATA_W-1:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // bounded wait for n words accepted since base
  task automatic wait_words(input int n);
    int t;
    t = 0;
    while (sink.words.size() < base + n) begin
      @(posedge clk);
      t++;
      if (t > 5000) begin
        num_errors++;
        $display("timeout waiting for stream words at %0t ns", $time);
        tally_and_finish();
      end
    end
  endtask

  function automatic logic [`DATA_W-1:0] prbs_next(
      input logic [`DATA_W-1:0] x);
    return x[0] ? ((x >> 1) ^ `PRBS_POLY) : (x >> 1);
  endfunction

  function automatic logic [`DATA_W-1:0] flip(input logic [`DATA_W-1:0] x,
                                              input logic f);
    return f ? ~x : x;
  endfunction

  task automatic run_custom(input int len_w, input int len, input int n,
                            input logic sl);
    int span;
    for (int i = 0; i < len; i++)
      wr(`PAT_BASE + 11'(4 * i), pat[i]);
    wr(`CUST_BASE + 11'h4, 32'(len_w));
    slow <= sl;
    base = sink.words.size();
    wr(`CUST_BASE, 32'h1);
    wait_words(n);
    for (int i = 0; i < n; i++)
      check(sink.words[base + i], pat[i % len]);
    span = sink.stamps[base + n - 1] - sink.stamps[base];
    if (!sl)
      check(32'(span), 32'(n - 1));
    // disable and let the output register drain before the next test
    wr(`CUST_BASE, 32'h0);
    slow <= 1'b0;
    repeat (4) @(posedge clk);
    $display("custom test length %0d done", len_w);
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    hold = 1'b0;
    slow = 1'b0;
    num_errors = 0;
    checks = 0;
    base = 0;
    void'($urandom(71047));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 check({31'h0, s_valid}, 32'h0);
    rd_check(`SEL_BASE, 32'h0);
    wr(`PAT_BASE + 11'h4, 32'h12345678);
    rd_check(`PAT_BASE + 11'h4, 32'h0);
    rd_check(11'h410, 32'h0);
    wr(11'h448, 32'h1);
    rd_check(`SEL_BASE, 32'h0);
    rd_check(`PRBS_BASE + 11'hC, `PRBS_SEED_RESET);
    $display("register test done");
    for (int i = 0; i < 32; i++)
      pat[i] = 32'h1 << i;
    run_custom(32, 32, 70, 1'b0);
    for (int i = 0; i < 32; i++)
      pat[i] = ~(32'h1 << i);
    run_custom(32, 32, 70, 1'b1);
    pat[0] = 32'hFFFFFFFF;
    pat[1] = 32'h00000000;
    run_custom(2, 2, 9, 1'b0);
    pat[0] = 32'hAAAAAAAA;
    pat[1] = 32'h55555555;
    run_custom(2, 2, 9, 1'b1);
    for (int i = 0; i < 256; i++)
      pat[i] = $urandom();
    run_custom(256, 256, 300, 1'b1);
    run_custom(0, 1, 5, 1'b0);
    rd_check(`CUST_BASE + 11'h4, 32'h1);
    wr(`CUST_BASE + 11'h4, 32'h1FF);
    rd_check(`CUST_BASE + 11'h4, 32'h100);
    wr(`SEL_BASE, 32'h1);
    rd_check(`SEL_BASE, 32'h1);
    for (int k = 0; k < 2; k++) begin
      v = k ? $urandom() : 32'h0;
      wr(`PRBS_BASE + 11'h4, v);
      slow <= k[0];
      base = sink.words.size();
      // second pass also inverts the stream
      wr(`PRBS_BASE, k ? 32'h3 : 32'h1);
      wait_words(40);
      w = flip((v == 0) ? 32'h1 : v, k[0]);
      check(sink.words[base], w);
      for (int i = 1; i < 40; i++) begin
        w = flip(prbs_next(flip(sink.words[base + i - 1], k[0])), k[0]);
        check(sink.words[base + i], w);
      end
      wr(`PRBS_BASE, 32'h0);
      slow <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("prbs test done");
    // switch sources while a word is held in the output register
    for (int i = 0; i < 4; i++)
      pat[i] = $urandom();
    hold <= 1'b1;
    wr(`SEL_BASE, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(`PAT_BASE + 11'(4 * i), pat[i]);
    wr(`CUST_BASE + 11'h4, 32'h4);
    v = $urandom() | 32'h1;
    wr(`PRBS_BASE + 11'h4, v);
    wr(`PRBS_BASE, 32'h1);
    base = sink.words.size();
    wr(`CUST_BASE, 32'h1);
    hold <= 1'b0;
    wait_words(3);
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    c1 = sink.words.size() - base;
    wr(`SEL_BASE, 32'h1);
    hold <= 1'b0;
    wait_words(c1 + 6);
    for (int i = 0; i <= c1; i++)
      check(sink.words[base + i], pat[i % 4]);
    check(sink.words[base + c1 + 1], v);
    for (int i = c1 + 2; i < c1 + 6; i++) begin
      w = prbs_next(sink.words[base + i - 1]);
      check(sink.words[base + i], w);
    end
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    c2 = sink.words.size() - base;
    wr(`SEL_BASE, 32'h0);
    hold <= 1'b0;
    wait_words(c2 + 3);
    w = prbs_next(sink.words[base + c2 - 1]);
    check(sink.words[base + c2], w);
    check(sink.words[base + c2 + 1], pat[(c1 + 1) % 4]);
    $display("switch test done");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 check({31'h0, s_valid}, 32'h0);
    check(s_data, 32'h0);
    rd_check(`SEL_BASE, 32'h0);
    $display("reset test done");
    tally_and_finish();
  end
endmodule // memory_test_pattern_source_test
